//--- rtl/tkw_map.vh
`ifndef TKW_MAP_VH
`define TKW_MAP_VH
// Clock rate and time base
`define TK_CLK_HZ 40000000
`define TK_TICK_HZ 100
`define TK_SQW_HZ 1024
`define TK_HALT_RST_MS 300
// Calendar and watchdog register offsets
`define TK_HSEC 16'h0000
`define TK_SEC 16'h0001
`define TK_MIN 16'h0002
`define TK_HOUR 16'h0003
`define TK_DAY 16'h0004
`define TK_DATE 16'h0005
`define TK_MONTH 16'h0006
`define TK_YEAR 16'h0007
`define TK_WD_HSEC 16'h0008
`define TK_WD_SEC 16'h0009
`define TK_CTL 16'h000a
`define TK_REG_TOP 16'h000e
// Memory size and extra registers above it
`define TK_MEM_BYTES 32768
`define TK_IRQ_STAT 16'h8000
`define TK_IRQ_CLR 16'h8001
`define TK_IRQ_EN 16'h8002
`define TK_RST_REASON 16'h8003
// Field positions
`define TK_HOUR_12H 6
`define TK_HOUR_PM 5
`define TK_CTL_SQW_EN 0
`define TK_EV_WD 0
`define TK_EV_SEC 1
`define TK_RR_WD 0
`define TK_RR_PIN 1
// Reset values
`define TK_HSEC_RST 8'h00
`define TK_DATE_RST 8'h01
`define TK_YEAR_RST 8'h00
`define TK_CTL_RST 8'h01
`endif

//--- rtl/timekeeper_watchdog_nvram.v
`timescale 1ns/1ps
`include "tkw_map.vh"
module timekeeper_watchdog_nvram #(
   parameter TICK_CYCLES = `TK_CLK_HZ / `TK_TICK_HZ,
   parameter SQW_HALF = `TK_CLK_HZ / (2 * `TK_SQW_HZ),
   parameter RST_DELAY = (`TK_CLK_HZ / 1000) * `TK_HALT_RST_MS
) (
   // Clock, reset, enable
   input wire core_clk,
   input wire rst,
   input wire ce,
   // Avalon-MM slave
   input wire [15:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [7:0] avs_writedata,
   output reg [7:0] avs_readdata,
   output reg avs_waitrequest,
   // Board pins
   input wire power_fail,
   input wire watchdog_expired_n_in,
   output reg watchdog_expired_n_out,
   output reg watchdog_expired_n_oe,
   output reg square_wave,
   // Processor and module control
   output reg cpu_halt,
   output reg module_reset,
   output reg irq
);
   localparam WD_OFF = 3'd0;
   localparam WD_RUN = 3'd1;
   localparam WD_HALT = 3'd2;
   localparam WD_WAIT = 3'd3;
   localparam WD_DONE = 3'd4;

   reg [7:0] mem [0:`TK_MEM_BYTES-1];
   reg [7:0] mem_q;
   reg [7:0] hsec, sec, min, hour, day, date, month, year;
   reg [7:0] wd_hs, wd_s, ctl;
   reg [1:0] irq_stat, irq_en;
   reg [1:0] rst_reason;
   reg [31:0] tick_cnt, sqw_cnt, dly_cnt;
   reg [13:0] wd_cnt;
   reg [2:0] wd_state;
   reg tick;
   reg pf_m, pf_s, wx_m, wx_s;
   reg stage;
   reg stage_ok;
   reg [15:0] addr_q;
   reg [7:0] next_hour;
   reg [7:0] hour_step;
   reg day_carry;
   reg [7:0] reg_rd;
   reg [1:0] ev;

   // Tens and ones of a packed BCD byte
   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   function [7:0] last_date;
      input [7:0] mo;
      input [7:0] yr;
      reg leap;
      begin
         leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
            (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
         case (mo)
            8'h02: last_date = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
            default: last_date = 8'h31;
         endcase
      end
   endfunction

   wire req = avs_read | avs_write;
   wire take = req & avs_waitrequest & ~stage;
   wire ok = take & ~pf_s;
   wire wr_ok = ok & avs_write;
   wire is_reg = avs_address < `TK_REG_TOP;
   wire in_mem = avs_address < `TK_MEM_BYTES;
   wire wd_access = ok & (avs_address == `TK_WD_HSEC || avs_address == `TK_WD_SEC);
   wire [7:0] nxt_wd_hs = (wr_ok && avs_address == `TK_WD_HSEC) ? avs_writedata : wd_hs;
   wire [7:0] nxt_wd_s = (wr_ok && avs_address == `TK_WD_SEC) ? avs_writedata : wd_s;
   // BCD seconds.hundredths to hundredths count
   wire [13:0] wd_load = {10'd0, nxt_wd_hs[3:0]} + nxt_wd_hs[7:4] * 14'd10 + nxt_wd_s[3:0] * 14'd100 +
      nxt_wd_s[7:4] * 14'd1000;

   // Hour step in either format
   always @* begin
      next_hour = hour;
      day_carry = 1'b0;
      hour_step = 8'h00;
      if (hour[`TK_HOUR_12H]) begin
         // Only the digit bits step; the mode bit stays put, the meridiem bit flips on 11 to 12
         hour_step = bcd_inc({3'b000, hour[4:0]});
         if (hour[4:0] == 5'h12)
            next_hour[4:0] = 5'h01;
         else if (hour[4:0] == 5'h11) begin
            next_hour[4:0] = 5'h12;
            next_hour[`TK_HOUR_PM] = ~hour[`TK_HOUR_PM];
            day_carry = hour[`TK_HOUR_PM];
         end else
            next_hour[4:0] = hour_step[4:0];
      end else begin
         hour_step = bcd_inc({2'b00, hour[5:0]});
         if (hour[5:0] == 6'h23) begin
            next_hour[5:0] = 6'h00;
            day_carry = 1'b1;
         end else
            next_hour[5:0] = hour_step[5:0];
      end
   end

   always @* begin
      case (addr_q)
         `TK_HSEC: reg_rd = hsec;
         `TK_SEC: reg_rd = sec;
         `TK_MIN: reg_rd = min;
         `TK_HOUR: reg_rd = hour;
         `TK_DAY: reg_rd = day;
         `TK_DATE: reg_rd = date;
         `TK_MONTH: reg_rd = month;
         `TK_YEAR: reg_rd = year;
         `TK_WD_HSEC: reg_rd = wd_hs;
         `TK_WD_SEC: reg_rd = wd_s;
         `TK_CTL: reg_rd = ctl;
         `TK_IRQ_STAT: reg_rd = {6'd0, irq_stat};
         `TK_IRQ_EN: reg_rd = {6'd0, irq_en};
         `TK_RST_REASON: reg_rd = {6'd0, rst_reason};
         // Unmapped bytes, where alarm settings would sit, read zero
         default: reg_rd = 8'h00;
      endcase
   end

   // General RAM above the register bytes
   always @(posedge core_clk) begin
      if (ce && ok && in_mem) begin
         if (avs_write && !is_reg)
            mem[avs_address[14:0]] <= avs_writedata;
         mem_q <= mem[avs_address[14:0]];
      end
   end

   // Bus handshake: take, then answer two cycles later
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 8'h00;
         stage <= 1'b0;
         stage_ok <= 1'b0;
         addr_q <= 16'h0000;
      end else if (ce) begin
         if (!avs_waitrequest)
            avs_waitrequest <= 1'b1;
         if (take) begin
            stage <= 1'b1;
            stage_ok <= ok;
            addr_q <= avs_address;
         end
         if (stage) begin
            stage <= 1'b0;
            avs_waitrequest <= 1'b0;
            if (!stage_ok)
               avs_readdata <= 8'h00;
            else if (addr_q >= `TK_REG_TOP && addr_q < `TK_MEM_BYTES)
               avs_readdata <= mem_q;
            else
               avs_readdata <= reg_rd;
         end
      end
   end

   // Pin synchronisers
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pf_m <= 1'b1;
         pf_s <= 1'b1;
         wx_m <= 1'b1;
         wx_s <= 1'b1;
      end else if (ce) begin
         pf_m <= power_fail;
         pf_s <= pf_m;
         wx_m <= watchdog_expired_n_in;
         wx_s <= wx_m;
      end
   end

   // Time base and square wave
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tick_cnt <= 32'd0;
         tick <= 1'b0;
         sqw_cnt <= 32'd0;
         square_wave <= 1'b0;
      end else if (ce) begin
         tick <= 1'b0;
         if (tick_cnt == TICK_CYCLES - 1) begin
            tick_cnt <= 32'd0;
            tick <= 1'b1;
         end else
            tick_cnt <= tick_cnt + 32'd1;
         if (sqw_cnt == SQW_HALF - 1) begin
            sqw_cnt <= 32'd0;
            square_wave <= ctl[`TK_CTL_SQW_EN] & ~square_wave;
         end else
            sqw_cnt <= sqw_cnt + 32'd1;
      end
   end

   // Calendar; a bus write in the same cycle wins
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hsec <= `TK_HSEC_RST;
         sec <= `TK_HSEC_RST;
         min <= `TK_HSEC_RST;
         hour <= `TK_HSEC_RST;
         day <= `TK_DATE_RST;
         date <= `TK_DATE_RST;
         month <= `TK_DATE_RST;
         year <= `TK_YEAR_RST;
         wd_hs <= 8'h00;
         wd_s <= 8'h00;
         ctl <= `TK_CTL_RST;
      end else if (ce) begin
         if (tick) begin
            if (hsec == 8'h99) begin
               hsec <= 8'h00;
               if (sec == 8'h59) begin
                  sec <= 8'h00;
                  if (min == 8'h59) begin
                     min <= 8'h00;
                     hour <= next_hour;
                     if (day_carry) begin
                        day <= (day == 8'h07) ? 8'h01 : bcd_inc(day);
                        if (date == last_date(month, year)) begin
                           date <= 8'h01;
                           if (month == 8'h12) begin
                              month <= 8'h01;
                              year <= (year == 8'h99) ? 8'h00 : bcd_inc(year);
                           end else
                              month <= bcd_inc(month);
                        end else
                           date <= bcd_inc(date);
                     end
                  end else
                     min <= bcd_inc(min);
               end else
                  sec <= bcd_inc(sec);
            end else
               hsec <= bcd_inc(hsec);
         end
         if (wr_ok) begin
            case (avs_address)
               `TK_HSEC: hsec <= avs_writedata;
               `TK_SEC: sec <= avs_writedata;
               `TK_MIN: min <= avs_writedata;
               `TK_HOUR: hour <= avs_writedata;
               `TK_DAY: day <= avs_writedata;
               `TK_DATE: date <= avs_writedata;
               `TK_MONTH: month <= avs_writedata;
               `TK_YEAR: year <= avs_writedata;
               `TK_WD_HSEC: wd_hs <= avs_writedata;
               `TK_WD_SEC: wd_s <= avs_writedata;
               `TK_CTL: ctl <= avs_writedata;
               default: ctl <= ctl;
            endcase
         end
      end
   end

   // Watchdog sequence
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wd_state <= WD_OFF;
         wd_cnt <= 14'd0;
         dly_cnt <= 32'd0;
         cpu_halt <= 1'b0;
         module_reset <= 1'b0;
         watchdog_expired_n_out <= 1'b0;
         watchdog_expired_n_oe <= 1'b0;
      end else if (ce) begin
         cpu_halt <= 1'b0;
         module_reset <= 1'b0;
         if (wd_access) begin
            wd_cnt <= wd_load;
            watchdog_expired_n_oe <= 1'b0;
            wd_state <= (wd_load == 14'd0) ? WD_OFF : WD_RUN;
         end else begin
            case (wd_state)
               WD_RUN: begin
                  if (tick) begin
                     wd_cnt <= wd_cnt - 14'd1;
                     if (wd_cnt == 14'd1)
                        wd_state <= WD_HALT;
                  end
               end
               WD_HALT: begin
                  cpu_halt <= 1'b1;
                  watchdog_expired_n_oe <= 1'b1;
                  dly_cnt <= 32'd0;
                  wd_state <= WD_WAIT;
               end
               WD_WAIT: begin
                  if (dly_cnt == RST_DELAY - 1) begin
                     module_reset <= 1'b1;
                     wd_state <= WD_DONE;
                  end else
                     dly_cnt <= dly_cnt + 32'd1;
               end
               default: wd_state <= wd_state;
            endcase
         end
      end
   end

   // Events, interrupt and reset reason
   always @* begin
      ev = 2'b00;
      ev[`TK_EV_WD] = (wd_state == WD_HALT) & ~wd_access;
      ev[`TK_EV_SEC] = tick & (hsec == 8'h99);
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_stat <= 2'b00;
         irq_en <= 2'b00;
         irq <= 1'b0;
         rst_reason <= 2'b00;
      end else if (ce) begin
         // Write 1 clears; a new event in the same cycle wins
         if (wr_ok && avs_address == `TK_IRQ_CLR)
            irq_stat <= (irq_stat & ~avs_writedata[1:0]) | ev;
         else
            irq_stat <= irq_stat | ev;
         if (wr_ok && avs_address == `TK_IRQ_EN)
            irq_en <= avs_writedata[1:0];
         irq <= |(irq_stat & irq_en);
         rst_reason[`TK_RR_PIN] <= ~wx_s;
         // Setting the reason beats a clearing write
         if (wd_state == WD_WAIT && dly_cnt == RST_DELAY - 1)
            rst_reason[`TK_RR_WD] <= 1'b1;
         else if (wr_ok && avs_address == `TK_RST_REASON && avs_writedata[`TK_RR_WD])
            rst_reason[`TK_RR_WD] <= 1'b0;
      end
   end
endmodule // timekeeper_watchdog_nvram

//--- verif/tkw_monitor.sv
`timescale 1ns/1ps
module tkw_monitor #(
   parameter SQW_HALF = 4,
   parameter RST_DELAY = 30
) (
   // Clock, reset and enable
   input wire core_clk,
   input wire rst,
   input wire ce,
   // Register bus
   input wire [15:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [7:0] avs_writedata,
   input wire [7:0] avs_readdata,
   input wire avs_waitrequest,
   // Pins and control
   input wire power_fail,
   input wire watchdog_expired_n_in,
   input wire watchdog_expired_n_out,
   input wire watchdog_expired_n_oe,
   input wire square_wave,
   input wire cpu_halt,
   input wire module_reset,
   input wire irq
);
   reg sq_q;
   reg sq_seen;
   reg ce_q;
   integer sc;
   integer hc;
   // Square wave run length in enabled cycles and cycles since the last halt
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sq_q <= 1'b0;
         sq_seen <= 1'b0;
         ce_q <= 1'b1;
         sc <= 0;
         hc <= 0;
      end else begin
         sq_q <= square_wave;
         ce_q <= ce;
         sc <= (square_wave != sq_q) ? 1 : ce_q ? sc + 1 : sc;
         sq_seen <= sq_seen | (square_wave != sq_q);
         hc <= cpu_halt ? 1 : hc + 1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_answer; $rose(avs_read | avs_write) |-> ##2 !avs_waitrequest; endproperty
   a_answer: assert property (p_answer) else $error("late bus answer");
   property p_wait; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("long answer");
   property p_pf; !avs_waitrequest && $past(avs_read, 2) && $past(power_fail, 4) && $past(power_fail, 2)
      |-> avs_readdata == 8'h00; endproperty
   a_pf: assert property (p_pf) else $error("read during power change");
   property p_sqw; sq_seen && square_wave != sq_q |-> sc == SQW_HALF; endproperty
   a_sqw: assert property (p_sqw) else $error("square wave half period");
   property p_halt; cpu_halt |=> !cpu_halt; endproperty
   a_halt: assert property (p_halt) else $error("halt pulse too long");
   property p_oe; cpu_halt |-> ##[0:1] watchdog_expired_n_oe; endproperty
   a_oe: assert property (p_oe) else $error("expired pin not pulled");
   property p_oc; watchdog_expired_n_oe |-> !watchdog_expired_n_out; endproperty
   a_oc: assert property (p_oc) else $error("expired pin driven high");
   property p_mr; module_reset |-> hc >= RST_DELAY - 1 && hc <= RST_DELAY + 1 ##1 !module_reset; endproperty
   a_mr: assert property (p_mr) else $error("module reset timing");
   c_halt: cover property (cpu_halt);
   c_mr: cover property (module_reset);
   c_irq: cover property (irq);
endmodule // tkw_monitor
bind timekeeper_watchdog_nvram tkw_monitor #(.SQW_HALF(SQW_HALF), .RST_DELAY(RST_DELAY)) tkw_monitor_i (
   .core_clk, .rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
   .avs_waitrequest, .power_fail, .watchdog_expired_n_in, .watchdog_expired_n_out,
   .watchdog_expired_n_oe, .square_wave, .cpu_halt, .module_reset, .irq);

//--- verif/nbus_bridge.sv
`timescale 1ns/1ps
module nbus_bridge (
   // Clock
   input wire core_clk,
   // Bus master side
   output logic [15:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [7:0] avs_writedata,
   input wire [7:0] avs_readdata,
   input wire avs_waitrequest
);
   initial begin
      avs_address = 16'hffff;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 8'h00;
   end
   // Single cycle held until waitrequest is seen low; released lines show inverted data
   task automatic xfer(input bit wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      repeat ($urandom % 3) @(posedge core_clk);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask
endmodule // nbus_bridge

//--- verif/tb_timekeeper_watchdog_nvram.sv
`timescale 1ns/1ps
`include "tkw_map.vh"
module tb_timekeeper_watchdog_nvram;
   localparam int TICK = 20;
   logic core_clk, rst, power_fail, ce;
   wire [15:0] avs_address;
   wire avs_read, avs_write, avs_waitrequest, wd_out, wd_oe, square_wave, cpu_halt, module_reset, irq;
   wire [7:0] avs_writedata, avs_readdata;
   wire wd_pin = wd_oe ? 1'b0 : 1'b1;
   int error_cnt = 0, n_tests = 0, halts = 0, resets = 0, cyc = 0, n, t0;
   logic [7:0] q, ram [logic [15:0]];
   logic [15:0] a;
   int tab [6][5] = '{'{4, 2, 28, 'h23, 0}, '{3, 2, 28, 'h71, 'h52}, '{4, 2, 29, 'h23, 0},
      '{5, 4, 30, 'h23, 0}, '{6, 1, 31, 'h51, 'h72}, '{99, 12, 31, 'h23, 0}};
   int y, m, d;
   timekeeper_watchdog_nvram #(.TICK_CYCLES(TICK), .SQW_HALF(4), .RST_DELAY(30)) timekeeper_watchdog_nvram_i (
      .core_clk(core_clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .power_fail(power_fail), .watchdog_expired_n_in(wd_pin),
      .watchdog_expired_n_out(wd_out), .watchdog_expired_n_oe(wd_oe), .square_wave(square_wave),
      .cpu_halt(cpu_halt), .module_reset(module_reset), .irq(irq));
   nbus_bridge nbus_bridge_i (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cpu_halt === 1'b1) halts <= halts + 1;
      if (module_reset === 1'b1) resets <= resets + 1;
   end
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [15:0] ad, logic [7:0] dt);
      logic [7:0] x;
      nbus_bridge_i.xfer(1'b1, ad, dt, x);
   endtask
   task automatic rchk(string what, logic [15:0] ad, logic [7:0] exp);
      logic [7:0] x;
      nbus_bridge_i.xfer(1'b0, ad, 8'h00, x);
      chk(what, exp, x);
   endtask
   function automatic logic [7:0] bcd(int v);
      return {4'(v / 10), 4'(v % 10)};
   endfunction
   function automatic int dim(int mo, int yr);
      if (mo == 2) return (yr % 4 == 0) ? 29 : 28;
      if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
      return 31;
   endfunction
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #500000;
      error_cnt++;
      end_sim();
   end
   initial begin
      rst <= 1'b1;
      ce <= 1'b1;
      power_fail <= 1'b0;
      void'($urandom(87840));
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      rchk("year", `TK_YEAR, 8'h00);
      rchk("date", `TK_DATE, 8'h01);
      rchk("ctl", `TK_CTL, 8'h01);
      $display("reset values done");
      for (int i = 0; i < 6; i++) begin
         a = i == 0 ? 16'h000e : i == 1 ? 16'h7fff : 16'h000e + 16'($urandom % 32754);
         ram[a] = 8'($urandom);
         wr(a, ram[a]);
      end
      foreach (ram[k]) rchk("ram", k, ram[k]);
      wr(16'h000b, 8'hff);
      rchk("gap", 16'h000b, 8'h00);
      power_fail <= 1'b1;
      repeat (4) @(posedge core_clk);
      wr(16'h000e, ~ram[16'h000e]);
      rchk("pf read", 16'h000e, 8'h00);
      power_fail <= 1'b0;
      repeat (4) @(posedge core_clk);
      rchk("pf ram", 16'h000e, ram[16'h000e]);
      $display("memory done");
      foreach (tab[r]) begin
         y = tab[r][0];
         m = tab[r][1];
         d = tab[r][2];
         wr(`TK_HSEC, 8'h00);
         wr(`TK_YEAR, bcd(y));
         wr(`TK_MONTH, bcd(m));
         wr(`TK_DATE, bcd(d));
         wr(`TK_HOUR, 8'(tab[r][3]));
         wr(`TK_DAY, 8'(r + 2));
         wr(`TK_MIN, 8'h59);
         wr(`TK_SEC, 8'h59);
         wr(`TK_HSEC, 8'h99);
         repeat (2 * TICK) @(posedge core_clk);
         if (tab[r][3] != 'h51) begin
            d = d == dim(m, y) ? 1 : d + 1;
            m = d == 1 ? m + 1 : m;
            y = m > 12 ? (y + 1) % 100 : y;
            m = m > 12 ? 1 : m;
         end
         rchk("sec", `TK_SEC, 8'h00);
         rchk("hour", `TK_HOUR, 8'(tab[r][4]));
         rchk("date", `TK_DATE, bcd(d));
         rchk("month", `TK_MONTH, bcd(m));
         rchk("year", `TK_YEAR, bcd(y));
         rchk("min", `TK_MIN, 8'h00);
         rchk("day", `TK_DAY, 8'(tab[r][3] == 'h51 ? r + 2 : r == 5 ? 1 : r + 3));
      end
      $display("calendar done");
      halts = 0;
      wr(`TK_WD_HSEC, 8'h05);
      rchk("wd load", `TK_WD_HSEC, 8'h05);
      repeat (6) begin
         repeat (TICK) @(posedge core_clk);
         rchk("wd sec", `TK_WD_SEC, 8'h00);
      end
      chk("kicked", 8'h00, 8'(halts));
      $display("watchdog kick done");
      wr(`TK_IRQ_EN, 8'h00);
      wr(`TK_WD_HSEC, 8'h03);
      t0 = cyc;
      n = 0;
      while (halts == 0 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      chk("expiry", 8'h01, {7'h0, cyc - t0 >= 2 * TICK - 3 && cyc - t0 <= 3 * TICK + 3});
      repeat (40) @(posedge core_clk);
      chk("resets", 8'h01, 8'(resets));
      chk("oe", 8'h01, {7'h0, wd_oe});
      rchk("reason", `TK_RST_REASON, 8'h03);
      chk("irq off", 8'h00, {7'h0, irq});
      wr(`TK_IRQ_EN, 8'h01);
      repeat (3) @(posedge core_clk);
      chk("irq on", 8'h01, {7'h0, irq});
      wr(`TK_IRQ_CLR, 8'h01);
      repeat (3) @(posedge core_clk);
      chk("irq clr", 8'h00, {7'h0, irq});
      wr(`TK_RST_REASON, 8'h01);
      wr(`TK_WD_HSEC, 8'h00);
      repeat (4) @(posedge core_clk);
      chk("oe off", 8'h00, {7'h0, wd_oe});
      rchk("reason clr", `TK_RST_REASON, 8'h00);
      $display("watchdog expiry done");
      // An odd number of half periods fits in the frozen span, so a running wave would differ
      wr(`TK_HSEC, 8'h00);
      ce <= 1'b0;
      @(posedge core_clk);
      t0 = square_wave;
      repeat (204) @(posedge core_clk);
      chk("ce sqw", 8'(t0), {7'h0, square_wave});
      ce <= 1'b1;
      nbus_bridge_i.xfer(1'b0, `TK_HSEC, 8'h00, q);
      chk("ce hold", 8'h01, {7'h0, q <= 8'h01});
      wr(`TK_CTL, 8'h00);
      repeat (10) @(posedge core_clk);
      chk("sqw off", 8'h00, {7'h0, square_wave});
      $display("clock enable done");
      end_sim();
   end
endmodule // tb_timekeeper_watchdog_nvram
